/* File: rtl/adt_cfg.svh */
// Register map, field positions, reset values and timing figures of the
// acceleration result bank. Definitions only; included by the time base and the result bank.
`ifndef ADT_CFG_SVH
`define ADT_CFG_SVH

// Register indices (byte address is four times the index)
`define ADT_IDX_AUX_CH4_HIGH 6'h11
`define ADT_IDX_ACCEL_X_LOW 6'h12
`define ADT_IDX_ACCEL_X_HIGH 6'h13
`define ADT_IDX_ACCEL_Y_LOW 6'h14
`define ADT_IDX_ACCEL_Y_HIGH 6'h15
`define ADT_IDX_ACCEL_Z_LOW 6'h16
`define ADT_IDX_ACCEL_Z_HIGH 6'h17
`define ADT_IDX_TIME_BYTE0 6'h18
`define ADT_IDX_TIME_BYTE1 6'h19
`define ADT_IDX_TIME_BYTE2 6'h1a
`define ADT_IDX_EVENT_FLAGS 6'h1b
`define ADT_IDX_FEATURE_IRQ 6'h1c
`define ADT_IDX_DATA_STATUS 6'h30
`define ADT_IDX_IRQ_STATUS 6'h31
`define ADT_IDX_IRQ_ENABLE 6'h32
`define ADT_IDX_IRQ_CLEAR 6'h33
`define ADT_IDX_CONTROL 6'h34

// Reset values
`define ADT_DATA_RESET 8'h00
`define ADT_EVENT_RESET 8'h01
`define ADT_IRQ_EN_RESET 3'h0
`define ADT_TIME_RUN_RESET 1'b1

// Field positions
`define ADT_EVT_POR_BIT 0
`define ADT_STS_DRDY_AUX_BIT 5
`define ADT_STS_DRDY_ACC_BIT 7
`define ADT_IRQ_ACC_BIT 0
`define ADT_IRQ_AUX_BIT 1
`define ADT_IRQ_POR_BIT 2
`define ADT_IRQ_COUNT 3
`define ADT_CTL_SOFT_RESET_BIT 0
`define ADT_CTL_TIME_RUN_BIT 1

// Timing: one time count step and the bus clock period, both in picoseconds
`define ADT_TIME_STEP_PS 39062500
`define ADT_CLK_PERIOD_PS 8000

`endif

/* File: rtl/adt_pkg.sv */
// Shared types of the acceleration result bank.
// Assumes adt_cfg.svh for all figures; holds types only.
package adt_pkg;
   typedef logic [7:0] adt_byte_type;
   typedef logic [15:0] adt_sample_type;
   typedef logic [5:0] adt_index_type;
endpackage

/* File: rtl/adt_time_base.sv */
// Free-running sensor time counter with a fractional step generator.
// Assumes one clock domain and a synchronous clear pulse from the bank.
`timescale 1ns/1ps
`default_nettype none
`include "adt_cfg.svh"
module adt_time_base #(
   parameter int WIDTH = 24,
   parameter logic [31:0] STEP_PS = `ADT_TIME_STEP_PS,
   parameter logic [31:0] CLK_PS = `ADT_CLK_PERIOD_PS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic clear,
   input wire logic run,
   // Count
   output logic [WIDTH-1:0] count_r
);
   logic [31:0] phase_r, phase_nxt;
   logic [WIDTH-1:0] count_nxt;

   // Phase accumulator keeps the average step exact although the step is no
   // whole number of clock periods; jitter is one clock at most
   always_comb begin
      phase_nxt = phase_r;
      count_nxt = count_r;
      if (clear) begin
         phase_nxt = '0;
         count_nxt = '0;
      end else if (run) begin
         if (phase_r + CLK_PS >= STEP_PS) begin
            phase_nxt = phase_r + CLK_PS - STEP_PS;
            count_nxt = count_r + 1'b1;
         end else begin
            phase_nxt = phase_r + CLK_PS;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= '0;
         count_r <= '0;
      end else begin
         phase_r <= phase_nxt;
         count_r <= count_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/adt_irq_ctrl.sv */
// Sticky interrupt status, enable mask and level interrupt output.
// Assumes event and write strobes are single-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
module adt_irq_ctrl #(
   parameter int N = 3
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Events and software access
   input wire logic [N-1:0] event_in,
   input wire logic clear_wr,
   input wire logic enable_wr,
   input wire logic [N-1:0] wr_data,
   // State and interrupt
   output logic [N-1:0] status_r,
   output logic [N-1:0] enable_r,
   output logic irq_r
);
   logic [N-1:0] status_nxt;
   logic [N-1:0] enable_nxt;
   logic irq_nxt;

   // Per bit: a new event wins over a clear in the same cycle
   for (genvar i = 0; i < N; i++) begin : g_bit
      always_comb begin
         status_nxt[i] = event_in[i] | (status_r[i] & ~(clear_wr & wr_data[i]));
      end
   end

   // Mask and level output are registered so the pin never glitches
   always_comb begin
      enable_nxt = enable_wr ? wr_data : enable_r;
      irq_nxt = |(status_nxt & enable_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= '0;
         enable_r <= '0;
         irq_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
         enable_r <= enable_nxt;
         irq_r <= irq_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/adt_result_bank.sv */
// Result register bank: aux channel four upper byte, three acceleration
// samples, 24-bit sensor time and the power-on event flag, on an APB slave.
// Assumes samples and the soft reset request come from logic on pclk.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "adt_cfg.svh"
// Function
// - Aux channel four upper byte is read-only at 0x11, resets to zero.
// - X, Y, Z samples as read-only low/high byte pairs 0x12 to 0x17, reset zero.
// - 24-bit time counter read as bytes at 0x18, 0x19, 0x1A, reset zero.
// - Time counter advances one step every 39.0625 microseconds.
// - Power-on flag bit 0 set after reset or soft reset, cleared on read.
// - Event register at 0x1B resets to 0x01, bits 7 to 1 read zero.
// - Accelerometer data-ready clears when any accelerometer data register is read.
module adt_result_bank #(
   parameter logic [31:0] TIME_STEP_PS = `ADT_TIME_STEP_PS,
   parameter logic [31:0] CLK_PERIOD_PS = `ADT_CLK_PERIOD_PS,
   parameter int TIME_WIDTH = 24
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sample sources, feature flags and soft reset request from the sensor core
   input wire logic [15:0] accel_x_in,
   input wire logic [15:0] accel_y_in,
   input wire logic [15:0] accel_z_in,
   input wire logic accel_valid,
   input wire logic [15:0] aux_ch4_in,
   input wire logic aux_valid,
   input wire logic [7:0] feature_irq_in,
   input wire logic soft_reset_req,
   // Interrupt
   output logic irq
);
   // Bus handshake state
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;

   // Data state
   adt_pkg::adt_byte_type aux_hi_r, aux_hi_nxt;
   adt_pkg::adt_sample_type acc_r [3];
   adt_pkg::adt_sample_type acc_nxt [3];
   adt_pkg::adt_byte_type acc_shadow_r [3];
   adt_pkg::adt_byte_type acc_shadow_nxt [3];
   logic [2:0] acc_lock_r, acc_lock_nxt;
   logic [15:0] time_shadow_r, time_shadow_nxt;
   logic time_lock_r, time_lock_nxt;
   logic drdy_acc_r, drdy_acc_nxt;
   logic drdy_aux_r, drdy_aux_nxt;
   logic por_r, por_nxt;
   logic time_run_r, time_run_nxt;

   // Decode and events
   adt_pkg::adt_index_type idx;
   logic aligned, hit, writable, dec_err;
   logic xfer_done, rd_done, wr_done;
   logic soft_rst;
   logic acc_read, aux_read, event_read;
   logic [TIME_WIDTH-1:0] time_count;
   logic [`ADT_IRQ_COUNT-1:0] irq_events, irq_status, irq_enable;
   logic irq_clear_wr, irq_enable_wr;
   logic irq_r;
   adt_pkg::adt_byte_type rd_byte;

   // Register index from a word address; byte offsets inside a word are refused
   assign idx = paddr[7:2];
   assign aligned = (paddr[1:0] == 2'b00);

   // A transfer completes on the edge that sees pready high in the access phase
   assign xfer_done = psel & penable & pready_r;
   assign rd_done = xfer_done & ~pwrite & ~dec_err;
   assign wr_done = xfer_done & pwrite & ~dec_err & pstrb[0];

   // Read side effects only on the completing edge, so wait states cost nothing
   assign acc_read = rd_done && idx >= `ADT_IDX_ACCEL_X_LOW && idx <= `ADT_IDX_ACCEL_Z_HIGH;
   assign aux_read = rd_done && idx == `ADT_IDX_AUX_CH4_HIGH;
   assign event_read = rd_done && idx == `ADT_IDX_EVENT_FLAGS;

   // Soft reset from the core or from the control register
   assign soft_rst = soft_reset_req |
      (wr_done && idx == `ADT_IDX_CONTROL && pwdata[`ADT_CTL_SOFT_RESET_BIT]);

   // Interrupt register strobes
   assign irq_clear_wr = wr_done && idx == `ADT_IDX_IRQ_CLEAR;
   assign irq_enable_wr = wr_done && idx == `ADT_IDX_IRQ_ENABLE;

   // Interrupt sources: new samples and a fresh power-on event
   always_comb begin
      irq_events = '0;
      irq_events[`ADT_IRQ_ACC_BIT] = accel_valid;
      irq_events[`ADT_IRQ_AUX_BIT] = aux_valid;
      irq_events[`ADT_IRQ_POR_BIT] = soft_rst;
   end

   // Read multiplexer and address check
   always_comb begin
      rd_byte = `ADT_DATA_RESET;
      hit = 1'b1;
      writable = 1'b0;
      case (idx)
         `ADT_IDX_AUX_CH4_HIGH: rd_byte = aux_hi_r;
         `ADT_IDX_ACCEL_X_LOW: rd_byte = acc_r[0][7:0];
         `ADT_IDX_ACCEL_X_HIGH: rd_byte = acc_lock_r[0] ? acc_shadow_r[0] : acc_r[0][15:8];
         `ADT_IDX_ACCEL_Y_LOW: rd_byte = acc_r[1][7:0];
         `ADT_IDX_ACCEL_Y_HIGH: rd_byte = acc_lock_r[1] ? acc_shadow_r[1] : acc_r[1][15:8];
         `ADT_IDX_ACCEL_Z_LOW: rd_byte = acc_r[2][7:0];
         `ADT_IDX_ACCEL_Z_HIGH: rd_byte = acc_lock_r[2] ? acc_shadow_r[2] : acc_r[2][15:8];
         `ADT_IDX_TIME_BYTE0: rd_byte = time_count[7:0];
         `ADT_IDX_TIME_BYTE1: rd_byte = time_lock_r ? time_shadow_r[7:0] : time_count[15:8];
         `ADT_IDX_TIME_BYTE2: rd_byte = time_lock_r ? time_shadow_r[15:8] : time_count[23:16];
         `ADT_IDX_EVENT_FLAGS: begin
            rd_byte[`ADT_EVT_POR_BIT] = por_r;
         end
         `ADT_IDX_FEATURE_IRQ: rd_byte = feature_irq_in;
         `ADT_IDX_DATA_STATUS: begin
            rd_byte[`ADT_STS_DRDY_ACC_BIT] = drdy_acc_r;
            rd_byte[`ADT_STS_DRDY_AUX_BIT] = drdy_aux_r;
         end
         `ADT_IDX_IRQ_STATUS: rd_byte[`ADT_IRQ_COUNT-1:0] = irq_status;
         `ADT_IDX_IRQ_ENABLE: begin
            rd_byte[`ADT_IRQ_COUNT-1:0] = irq_enable;
            writable = 1'b1;
         end
         `ADT_IDX_IRQ_CLEAR: writable = 1'b1;
         `ADT_IDX_CONTROL: begin
            rd_byte[`ADT_CTL_TIME_RUN_BIT] = time_run_r;
            writable = 1'b1;
         end
         default: hit = 1'b0;
      endcase
      // Writes to read-only results are refused with an error, not dropped silently
      dec_err = ~aligned | ~hit | (pwrite & ~writable);
   end

   // APB answer: one wait state, data and error registered with pready
   always_comb begin
      pready_nxt = psel & penable & ~pready_r;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata_r;
      if (psel && penable && !pready_r) begin
         pslverr_nxt = dec_err;
         prdata_nxt = (pwrite || dec_err) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // Sample capture and burst coherence
   always_comb begin
      aux_hi_nxt = aux_hi_r;
      acc_lock_nxt = acc_lock_r;
      time_shadow_nxt = time_shadow_r;
      time_lock_nxt = time_lock_r;
      for (int k = 0; k < 3; k++) begin
         acc_nxt[k] = acc_r[k];
         acc_shadow_nxt[k] = acc_shadow_r[k];
      end
      if (aux_valid) begin
         aux_hi_nxt = aux_ch4_in[15:8];
      end
      if (accel_valid) begin
         acc_nxt[0] = accel_x_in;
         acc_nxt[1] = accel_y_in;
         acc_nxt[2] = accel_z_in;
      end
      // Low-byte read freezes the matching upper byte until it is read
      for (int k = 0; k < 3; k++) begin
         if (rd_done && idx == `ADT_IDX_ACCEL_X_LOW + 6'(2 * k)) begin
            acc_shadow_nxt[k] = acc_r[k][15:8];
            acc_lock_nxt[k] = 1'b1;
         end else if (rd_done && idx == `ADT_IDX_ACCEL_X_HIGH + 6'(2 * k)) begin
            acc_lock_nxt[k] = 1'b0;
         end
      end
      // Time byte 0 read freezes bytes 1 and 2; byte 2 read ends the burst
      if (rd_done && idx == `ADT_IDX_TIME_BYTE0) begin
         time_shadow_nxt = time_count[23:8];
         time_lock_nxt = 1'b1;
      end else if (rd_done && idx == `ADT_IDX_TIME_BYTE2) begin
         time_lock_nxt = 1'b0;
      end
      // Soft reset returns every result to its reset value
      if (soft_rst) begin
         aux_hi_nxt = `ADT_DATA_RESET;
         acc_lock_nxt = 3'h0;
         time_lock_nxt = 1'b0;
         for (int k = 0; k < 3; k++) begin
            acc_nxt[k] = 16'h0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_hi_r <= `ADT_DATA_RESET;
         acc_lock_r <= 3'h0;
         time_shadow_r <= 16'h0000;
         time_lock_r <= 1'b0;
         for (int k = 0; k < 3; k++) begin
            acc_r[k] <= 16'h0000;
            acc_shadow_r[k] <= `ADT_DATA_RESET;
         end
      end else begin
         aux_hi_r <= aux_hi_nxt;
         acc_lock_r <= acc_lock_nxt;
         time_shadow_r <= time_shadow_nxt;
         time_lock_r <= time_lock_nxt;
         for (int k = 0; k < 3; k++) begin
            acc_r[k] <= acc_nxt[k];
            acc_shadow_r[k] <= acc_shadow_nxt[k];
         end
      end
   end

   // Flags: a setting event in the clearing cycle wins, so none is lost
   always_comb begin
      drdy_acc_nxt = accel_valid | (drdy_acc_r & ~acc_read);
      drdy_aux_nxt = aux_valid | (drdy_aux_r & ~aux_read);
      por_nxt = soft_rst | (por_r & ~event_read);
      time_run_nxt = time_run_r;
      if (wr_done && idx == `ADT_IDX_CONTROL) begin
         time_run_nxt = pwdata[`ADT_CTL_TIME_RUN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drdy_acc_r <= 1'b0;
         drdy_aux_r <= 1'b0;
         por_r <= 1'(`ADT_EVENT_RESET);
         time_run_r <= `ADT_TIME_RUN_RESET;
      end else begin
         drdy_acc_r <= drdy_acc_nxt;
         drdy_aux_r <= drdy_aux_nxt;
         por_r <= por_nxt;
         time_run_r <= time_run_nxt;
      end
   end

   // Sensor time base; cleared by soft reset
   adt_time_base #(
      .WIDTH(TIME_WIDTH),
      .STEP_PS(TIME_STEP_PS),
      .CLK_PS(CLK_PERIOD_PS)
   ) u_time (
      .pclk(pclk),
      .presetn(presetn),
      .clear(soft_rst),
      .run(time_run_r),
      .count_r(time_count)
   );

   // Interrupt status, mask and level output
   adt_irq_ctrl #(
      .N(`ADT_IRQ_COUNT)
   ) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .event_in(irq_events),
      .clear_wr(irq_clear_wr),
      .enable_wr(irq_enable_wr),
      .wr_data(pwdata[`ADT_IRQ_COUNT-1:0]),
      .status_r(irq_status),
      .enable_r(irq_enable),
      .irq_r(irq_r)
   );

   // Outputs straight from flip-flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
endmodule
`default_nettype wire

/* File: tb/adt_host_model.sv */
// APB host model: runs one transfer at a time on the result bank.
// Assumes the slave answers with pready; the bench watchdog cuts hangs.
`timescale 1ns/1ps
`default_nettype none
module adt_host_model (
   // Clock
   input wire logic pclk,
   // APB request
   output var logic psel,
   output var logic penable,
   output var logic pwrite,
   output var logic [7:0] paddr,
   output var logic [31:0] pwdata,
   output var logic [3:0] pstrb,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
   end
   // Setup, then access held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/adt_bank_assertions.sv */
// Protocol and access checks on the result bank's ports.
// Assumes one clock domain; bound into every result bank instance.
`timescale 1ns/1ps
`default_nettype none
module adt_bank_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core side
   input wire logic accel_valid,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Result registers 0x11 to 0x1b take no writes
   logic ro_hit;
   assign ro_hit = (paddr[7:2] >= 6'h11) && (paddr[7:2] <= 6'h1b);
   property p_ans_lat; psel && penable && !pready |=> pready; endproperty
   a_ans_lat: assert property (p_ans_lat) else $error("pready late");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
   property p_rdy_acc; pready |-> psel && penable; endproperty
   a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
   property p_ro_wr; pready && pwrite && ro_hit |-> pslverr; endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("write accepted");
   property p_align; pready && (paddr[1:0] != 2'h0) |-> pslverr; endproperty
   a_align: assert property (p_align) else $error("misaligned accepted");
   property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("data on error");
   property p_byte; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_byte: assert property (p_byte) else $error("upper read bits set");
   property p_evt; pready && !pwrite && paddr == 8'h6c |-> prdata[7:1] == 7'h0; endproperty
   a_evt: assert property (p_evt) else $error("event reserved bits set");
   property p_hold; !pready |-> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("prdata moved");
   c_evt: cover property (pready && paddr == 8'h6c && prdata[0]);
   c_err: cover property (pready && pslverr);
   c_irq: cover property ($rose(irq));
   c_smp: cover property (accel_valid);
endmodule
bind adt_result_bank adt_bank_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .accel_valid(accel_valid), .irq(irq));
`default_nettype wire

/* File: tb/tb_accel_data_time_event_regs.sv */
// Self-checking bench of the result bank through the APB host model.
// Assumes a shortened time step of ten clock cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_accel_data_time_event_regs;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq;
   logic accel_valid = 1'b0;
   logic aux_valid = 1'b0;
   logic soft_req = 1'b0;
   logic [7:0] paddr, t0;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [15:0] ax = 16'h0, ay = 16'h0, az = 16'h0, aux = 16'h0;
   int miscompares = 0;
   int n_checks = 0;
   // 125 MHz bus clock
   always #4 pclk = ~pclk;
   adt_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // Step every ten cycles keeps the time test short
   adt_result_bank #(.TIME_STEP_PS(32'd80000)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .accel_x_in(ax), .accel_y_in(ay), .accel_z_in(az), .accel_valid(accel_valid),
      .aux_ch4_in(aux), .aux_valid(aux_valid), .feature_irq_in(8'h5a),
      .soft_reset_req(soft_req), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Read and compare the masked value; a clean answer is expected
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffffffff);
      logic e;
      i_host.xfer(1'b0, a, 32'h0, q, e);
      chk(q & m, exp);
      chk({31'h0, e}, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      logic [31:0] r;
      i_host.xfer(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0);
   endtask
   // Refused access: error flagged, no data
   task automatic bad(input logic w, input logic [7:0] a);
      logic e;
      logic [31:0] r;
      i_host.xfer(w, a, 32'hff, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
   endtask
   // Samples change just after an edge with one-cycle valid pulses
   task automatic load(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      @(posedge pclk);
      ax <= x;
      ay <= y;
      az <= z;
      aux <= ~x;
      accel_valid <= 1'b1;
      aux_valid <= 1'b1;
      @(posedge pclk);
      accel_valid <= 1'b0;
      aux_valid <= 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Watchdog well beyond the few thousand cycles of the tests
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      $display("MISMATCH %0t watchdog", $time);
      test_done;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h6c, 32'h1);
      rd(8'h6c, 32'h0);
      for (int i = 'h44; i <= 'h5c; i += 4) rd(8'(i), 32'h0);
      rd(8'h68, 32'h0);
      rd(8'h70, 32'h5a);
      $display("test reset done");
      load(16'h1234, 16'h5678, 16'h9abc);
      rd(8'hc0, 32'ha0);
      rd(8'h44, 32'hed);
      rd(8'hc0, 32'h80);
      rd(8'h48, 32'h34);
      rd(8'hc0, 32'h00);
      rd(8'h4c, 32'h12);
      rd(8'h50, 32'h78);
      rd(8'h54, 32'h56);
      rd(8'h58, 32'hbc);
      rd(8'h5c, 32'h9a);
      $display("test samples done");
      // Upper byte must stay with the low byte already read
      load(16'haa11, 16'h0, 16'h0);
      rd(8'h48, 32'h11);
      load(16'hbb22, 16'h0, 16'h0);
      rd(8'h4c, 32'haa);
      rd(8'h4c, 32'hbb);
      bad(1'b1, 8'h44);
      bad(1'b1, 8'h48);
      bad(1'b1, 8'h60);
      bad(1'b1, 8'h6c);
      bad(1'b0, 8'h49);
      bad(1'b0, 8'h80);
      rd(8'h48, 32'h22);
      $display("test burst done");
      wr(8'hd0, 32'h0);
      rd(8'h60, 32'h0, 32'hffffff00);
      t0 = q[7:0];
      repeat (30) @(posedge pclk);
      rd(8'h60, {24'h0, t0});
      rd(8'h64, 32'h0);
      rd(8'h68, 32'h0);
      wr(8'hd0, 32'h2);
      repeat (97) @(posedge pclk);
      wr(8'hd0, 32'h0);
      rd(8'h60, 32'h0, 32'hffffff00);
      chk({31'h0, (8'(q[7:0] - t0) inside {8'd10, 8'd11})}, 32'h1);
      wr(8'hd0, 32'h2);
      $display("test time done");
      wr(8'hcc, 32'h7);
      wr(8'hc8, 32'h1);
      load(16'h0001, 16'h0, 16'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      rd(8'hc4, 32'h1, 32'h1);
      wr(8'hcc, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(8'hc8, 32'h0);
      load(16'h0002, 16'h0, 16'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd(8'hc4, 32'h1, 32'h1);
      $display("test irq done");
      wr(8'hd0, 32'h3);
      rd(8'h6c, 32'h1);
      rd(8'h48, 32'h0);
      // Core soft reset request sets the flag again and restarts the time count
      @(posedge pclk);
      soft_req <= 1'b1;
      @(posedge pclk);
      soft_req <= 1'b0;
      rd(8'h6c, 32'h1);
      // About 260 steps later the middle time byte has just turned to one
      repeat (2600) @(posedge pclk);
      rd(8'h60, 32'h0, 32'hffffff00);
      rd(8'h64, 32'h1);
      rd(8'h68, 32'h0);
      $display("test soft reset done");
      test_done;
   end
endmodule
`default_nettype wire
